// ==== rtl/dcf_fifo.sv ====
// dual clock 9-bit fifo with programmable almost-empty/almost-full flags
`timescale 1ns/1ps
// Overview of operation
// - dual-port array of 64 nine-bit words, separate write and read pointers.
// - reset empties the fifo, empty flag low, all flags valid.
// - data outputs are low after reset is released.
// - primary enable low and second enable high stores a word each edge.
// - both read enables low presents the next word each read edge.
// - writes fill the array independently of read activity.
// - output enable low drives data outputs, high floats them.
// - writes while full are ignored, pointers and contents unchanged.
// - reads while empty are ignored, outputs keep last word.
// - first word readable one read edge after empty flag rises.
// - almost-empty may change one read edge late on close clock edges.
// - almost-full may change one write edge late on close clock edges.
// - dual pin high at reset becomes active-high second write enable.
// - dual pin low at reset selects threshold mode and load strobe.
// - load strobe gives read and write access to four byte thresholds.
// - loads go empty-low, empty-high, full-low, full-high in turn.
// - fifth load wraps back to the empty-low register.
// - raising load keeps the sequence position for the next access.
// - load low with reads enabled reads thresholds out in same order.
// - almost-empty low at n or fewer words, high at n+1 or more.
// - almost-full low at depth minus m words, high when free exceeds m.
// - both thresholds default to seven.
// - full flag moves on write edges only, empty on read edges only.

module dcf_fifo
(
   input wire logic ref_clk_i,
   input wire logic rd_clk_i,
   input wire logic reset_i,
   input wire logic primary_write_enable_n_i,
   input wire logic second_enable_or_load_n_i,
   input wire logic [dcf_pkg::DATA_W-1:0] write_data_i,
   input wire logic read_enable_a_n_i,
   input wire logic read_enable_b_n_i,
   input wire logic output_enable_n_i,
   output logic [dcf_pkg::DATA_W-1:0] read_data_o,
   output logic read_data_oe_o,
   output logic empty_flag_n_o,
   output logic full_flag_n_o,
   output logic almost_empty_flag_n_o,
   output logic almost_full_flag_n_o
);

   // ==========================================================
   // declarations
   // ==========================================================
   localparam int PW = dcf_pkg::PTR_W;
   localparam int AW = dcf_pkg::ADDR_W;

   logic [dcf_pkg::DATA_W-1:0] mem_r [dcf_pkg::DEPTH];
   logic mode_dual_r;
   logic strap_done_r;
   logic [PW-1:0] wbin_r;
   logic [PW-1:0] wgray_r;
   logic [PW-1:0] rgray_ws1_r;
   logic [PW-1:0] rgray_ws2_r;
   logic full_flag_n_r;
   logic almost_full_flag_n_r;
   dcf_pkg::dcf_ofs_t ofs_r;
   dcf_pkg::dcf_sel_t wsel_r;
   logic push_req;
   logic push;
   logic load_wr;
   logic [PW-1:0] wbin_nxt;
   logic [PW-1:0] wgray_nxt;
   logic [PW-1:0] wcount_nxt;
   logic [PW-1:0] m_val;
   logic [2*dcf_pkg::OFS_W-1:0] full_ofs;
   logic [2*dcf_pkg::OFS_W-1:0] empty_ofs;

   logic rd_rst_s1_r;
   logic rd_rst_r;
   logic [PW-1:0] wgray_rs1_r;
   logic [PW-1:0] wgray_rs2_r;
   logic ld_rs1_r;
   logic ld_rs2_r;
   logic mode_rs1_r;
   logic mode_rs2_r;
   logic strap_rs1_r;
   logic strap_rs2_r;
   logic oe_s1_r;
   logic oe_r;
   logic [PW-1:0] n_rs1_r;
   logic [PW-1:0] n_rs2_r;
   logic [PW-1:0] rbin_r;
   logic [PW-1:0] rgray_r;
   logic empty_flag_n_r;
   logic almost_empty_flag_n_r;
   logic [dcf_pkg::DATA_W-1:0] read_data_r;
   dcf_pkg::dcf_sel_t rsel_r;
   logic pop_req;
   logic pop;
   logic prog_rd;
   logic [PW-1:0] rbin_nxt;
   logic [PW-1:0] rgray_nxt;
   logic [PW-1:0] rcount_nxt;

   // next threshold register in the load order
   function automatic dcf_pkg::dcf_sel_t sel_next
      (input dcf_pkg::dcf_sel_t s);
      case (s)
         dcf_pkg::DCF_SEL_EMPTY_LO: sel_next = dcf_pkg::DCF_SEL_EMPTY_HI;
         dcf_pkg::DCF_SEL_EMPTY_HI: sel_next = dcf_pkg::DCF_SEL_FULL_LO;
         dcf_pkg::DCF_SEL_FULL_LO: sel_next = dcf_pkg::DCF_SEL_FULL_HI;
         default: sel_next = dcf_pkg::DCF_SEL_EMPTY_LO;
      endcase
   endfunction

   // ==========================================================
   // write domain: mode strap
   // ==========================================================
   // catch the dual pin on the first edge after reset release
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mode_dual_r <= 1'b0;
         strap_done_r <= 1'b0;
      end
      else if (!strap_done_r)
      begin
         mode_dual_r <= second_enable_or_load_n_i;
         strap_done_r <= 1'b1;
      end
   end

   // ==========================================================
   // write domain: request decode and flag arithmetic
   // ==========================================================
   // the pin must be high to push in either mode
   always_comb
   begin
      push_req = strap_done_r && !primary_write_enable_n_i &&
                 second_enable_or_load_n_i;
      push = push_req && full_flag_n_r;
      load_wr = strap_done_r && !mode_dual_r &&
                !primary_write_enable_n_i &&
                !second_enable_or_load_n_i;
      wbin_nxt = wbin_r + {{(PW-1){1'b0}}, push};
      wgray_nxt = (wbin_nxt >> 1) ^ wbin_nxt;
      wcount_nxt = wbin_nxt - dcf_pkg::dcf_gray2bin(rgray_ws2_r);
      full_ofs = {ofs_r.full_hi, ofs_r.full_lo};
      empty_ofs = {ofs_r.empty_hi, ofs_r.empty_lo};
      m_val = full_ofs[PW-1:0];
   end

   // ==========================================================
   // write domain: storage
   // ==========================================================
   // array entries, written only by the write clock
   always_ff @(posedge ref_clk_i)
   begin
      if (push)
      begin
         mem_r[wbin_r[AW-1:0]] <= write_data_i;
      end
   end

   // write pointer in binary and gray
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wbin_r <= '0;
         wgray_r <= '0;
      end
      else
      begin
         wbin_r <= wbin_nxt;
         wgray_r <= wgray_nxt;
      end
   end

   // read pointer into write domain, close edges cost one edge
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rgray_ws1_r <= '0;
         rgray_ws2_r <= '0;
      end
      else
      begin
         rgray_ws1_r <= rgray_r;
         rgray_ws2_r <= rgray_ws1_r;
      end
   end

   // full and almost-full, moved by write edges alone
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         full_flag_n_r <= 1'b1;
         almost_full_flag_n_r <= 1'b1;
      end
      else
      begin
         full_flag_n_r <= (wcount_nxt != dcf_pkg::DEPTH_P);
         // pin level kept in the flop so the output needs no gate
         almost_full_flag_n_r <=
            (wcount_nxt < dcf_pkg::DEPTH_P - m_val);
      end
   end

   // threshold registers, loaded in sequence
   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ofs_r <= dcf_pkg::OFS_RST;
         wsel_r <= dcf_pkg::DCF_SEL_EMPTY_LO;
      end
      else if (load_wr)
      begin
         case (wsel_r)
            dcf_pkg::DCF_SEL_EMPTY_LO: ofs_r.empty_lo <= write_data_i[7:0];
            dcf_pkg::DCF_SEL_EMPTY_HI: ofs_r.empty_hi <= write_data_i[7:0];
            dcf_pkg::DCF_SEL_FULL_LO: ofs_r.full_lo <= write_data_i[7:0];
            default: ofs_r.full_hi <= write_data_i[7:0];
         endcase
         wsel_r <= sel_next(wsel_r);
      end
   end

   // ==========================================================
   // read domain: reset release and level crossings
   // ==========================================================
   // reset asserts at once, releases on the read clock
   always_ff @(posedge rd_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rd_rst_s1_r <= 1'b1;
         rd_rst_r <= 1'b1;
      end
      else
      begin
         rd_rst_s1_r <= 1'b0;
         rd_rst_r <= rd_rst_s1_r;
      end
   end

   // two-stage synchronisers into the read domain
   always_ff @(posedge rd_clk_i or posedge rd_rst_r)
   begin
      if (rd_rst_r)
      begin
         wgray_rs1_r <= '0;
         wgray_rs2_r <= '0;
         ld_rs1_r <= 1'b1;
         ld_rs2_r <= 1'b1;
         mode_rs1_r <= 1'b0;
         mode_rs2_r <= 1'b0;
         strap_rs1_r <= 1'b0;
         strap_rs2_r <= 1'b0;
         n_rs1_r <= '0;
         n_rs2_r <= '0;
      end
      else
      begin
         wgray_rs1_r <= wgray_r;
         wgray_rs2_r <= wgray_rs1_r;
         ld_rs1_r <= second_enable_or_load_n_i;
         ld_rs2_r <= ld_rs1_r;
         mode_rs1_r <= mode_dual_r;
         mode_rs2_r <= mode_rs1_r;
         strap_rs1_r <= strap_done_r;
         strap_rs2_r <= strap_rs1_r;
         n_rs1_r <= empty_ofs[PW-1:0]; // quasi-static
         n_rs2_r <= n_rs1_r;
      end
   end

   // output enable pin, two flops then straight out
   always_ff @(posedge rd_clk_i or posedge rd_rst_r)
   begin
      if (rd_rst_r)
      begin
         oe_s1_r <= 1'b0;
         oe_r <= 1'b0;
      end
      else
      begin
         oe_s1_r <= !output_enable_n_i;
         oe_r <= oe_s1_r;
      end
   end

   // ==========================================================
   // read domain: request decode and flag arithmetic
   // ==========================================================
   // threshold reads take the read enables away from the fifo
   always_comb
   begin
      prog_rd = strap_rs2_r && !mode_rs2_r && !ld_rs2_r &&
                !read_enable_a_n_i && !read_enable_b_n_i;
      pop_req = !read_enable_a_n_i && !read_enable_b_n_i &&
                (mode_rs2_r || ld_rs2_r);
      pop = pop_req && empty_flag_n_r;
      rbin_nxt = rbin_r + {{(PW-1){1'b0}}, pop};
      rgray_nxt = (rbin_nxt >> 1) ^ rbin_nxt;
      rcount_nxt = dcf_pkg::dcf_gray2bin(wgray_rs2_r) - rbin_nxt;
   end

   // read pointer in binary and gray
   always_ff @(posedge rd_clk_i or posedge rd_rst_r)
   begin
      if (rd_rst_r)
      begin
         rbin_r <= '0;
         rgray_r <= '0;
      end
      else
      begin
         rbin_r <= rbin_nxt;
         rgray_r <= rgray_nxt;
      end
   end

   // empty and almost-empty, moved by read edges alone
   always_ff @(posedge rd_clk_i or posedge rd_rst_r)
   begin
      if (rd_rst_r)
      begin
         empty_flag_n_r <= 1'b0;
         almost_empty_flag_n_r <= 1'b0;
      end
      else
      begin
         empty_flag_n_r <= (rcount_nxt != '0);
         almost_empty_flag_n_r <= (rcount_nxt > n_rs2_r);
      end
   end

   // output register: fifo word or threshold byte
   // thresholds are read live; loading them meanwhile is unsafe
   always_ff @(posedge rd_clk_i or posedge rd_rst_r)
   begin
      if (rd_rst_r)
      begin
         read_data_r <= '0;
         rsel_r <= dcf_pkg::DCF_SEL_EMPTY_LO;
      end
      else if (pop)
      begin
         read_data_r <= mem_r[rbin_r[AW-1:0]];
      end
      else if (prog_rd)
      begin
         case (rsel_r)
            dcf_pkg::DCF_SEL_EMPTY_LO: read_data_r <= {1'b0, ofs_r.empty_lo};
            dcf_pkg::DCF_SEL_EMPTY_HI: read_data_r <= {1'b0, ofs_r.empty_hi};
            dcf_pkg::DCF_SEL_FULL_LO: read_data_r <= {1'b0, ofs_r.full_lo};
            default: read_data_r <= {1'b0, ofs_r.full_hi};
         endcase
         rsel_r <= sel_next(rsel_r);
      end
   end

   // ==========================================================
   // outputs
   // ==========================================================
   assign read_data_o = read_data_r;
   assign read_data_oe_o = oe_r;
   assign empty_flag_n_o = empty_flag_n_r;
   assign full_flag_n_o = full_flag_n_r;
   assign almost_empty_flag_n_o = almost_empty_flag_n_r;
   assign almost_full_flag_n_o = almost_full_flag_n_r;

   // ==========================================================
   // assertions
   // ==========================================================
   a_full_blocks_write: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      (push_req && !full_flag_n_r) |=> $stable(wbin_r))
      else $error("write taken while full");

   a_empty_blocks_read: assert property (
      @(posedge rd_clk_i) disable iff (rd_rst_r)
      (pop_req && !empty_flag_n_r) |=> $stable(rbin_r) &&
      $stable(read_data_r))
      else $error("read taken while empty");

   a_write_advances: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      push |=> wbin_r == $past(wbin_r) + 7'h01)
      else $error("write pointer did not advance");

   a_load_first_reg: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      (load_wr && wsel_r == dcf_pkg::DCF_SEL_EMPTY_LO) |=>
      ofs_r.empty_lo == $past(write_data_i[7:0]) &&
      wsel_r == dcf_pkg::DCF_SEL_EMPTY_HI)
      else $error("empty low threshold not loaded");

   a_load_wraps: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      (load_wr && wsel_r == dcf_pkg::DCF_SEL_FULL_HI) |=>
      wsel_r == dcf_pkg::DCF_SEL_EMPTY_LO)
      else $error("load sequence did not wrap");

   a_load_keeps_pos: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      !load_wr |=> $stable(wsel_r) && $stable(ofs_r))
      else $error("threshold state moved without load");

   a_prog_no_push: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      (strap_done_r && !mode_dual_r && !second_enable_or_load_n_i)
      |=> $stable(wbin_r))
      else $error("fifo written during threshold load");

   a_full_at_depth: assert property (
      @(posedge ref_clk_i) disable iff (reset_i)
      (wcount_nxt == dcf_pkg::DEPTH_P) |=> !full_flag_n_r &&
      !almost_full_flag_n_r)
      else $error("full flags not set at depth");

   a_almost_empty: assert property (
      @(posedge rd_clk_i) disable iff (rd_rst_r)
      (rcount_nxt > n_rs2_r) |=> almost_empty_flag_n_r)
      else $error("almost-empty low above threshold");

   a_reset_data_low: assert property (
      @(posedge rd_clk_i) disable iff (reset_i)
      $fell(rd_rst_r) |-> read_data_r == '0 && !empty_flag_n_r)
      else $error("outputs not cleared by reset");

   c_fifo_full: cover property (
      @(posedge ref_clk_i) disable iff (reset_i) !full_flag_n_r);

   c_load_wrap: cover property (
      @(posedge ref_clk_i) disable iff (reset_i)
      load_wr && wsel_r == dcf_pkg::DCF_SEL_FULL_HI);

   c_prog_read: cover property (
      @(posedge rd_clk_i) disable iff (rd_rst_r) prog_rd);

   c_first_word: cover property (
      @(posedge rd_clk_i) disable iff (rd_rst_r)
      $rose(empty_flag_n_r) ##1 pop);

endmodule // dcf_fifo

// ==== rtl/dcf_pkg.sv ====
// shared constants, types and helpers for the dual clock fifo
package dcf_pkg;

   // ==========================================================
   // geometry
   // ==========================================================
   localparam int DATA_W = 9;          // stored word width
   localparam int ADDR_W = 6;          // 64 entries (smallest depth)
   localparam int PTR_W = ADDR_W + 1;  // pointer with wrap bit
   localparam int DEPTH = 1 << ADDR_W;
   localparam int OFS_W = 8;           // each threshold byte register
   localparam logic [PTR_W-1:0] DEPTH_P = PTR_W'(DEPTH);

   // ==========================================================
   // reset values of the threshold registers (n = m = 7)
   // ==========================================================
   localparam logic [OFS_W-1:0] EMPTY_LO_RST = 8'h07;
   localparam logic [OFS_W-1:0] EMPTY_HI_RST = 8'h00;
   localparam logic [OFS_W-1:0] FULL_LO_RST = 8'h07;
   localparam logic [OFS_W-1:0] FULL_HI_RST = 8'h00;

   // ==========================================================
   // types
   // ==========================================================
   // threshold register selector, gray coded along the load order
   typedef enum logic [1:0]
   {
      DCF_SEL_EMPTY_LO = 2'h0,
      DCF_SEL_EMPTY_HI = 2'h1,
      DCF_SEL_FULL_LO = 2'h3,
      DCF_SEL_FULL_HI = 2'h2
   } dcf_sel_t;

   // the four threshold registers as one bundle
   typedef struct packed
   {
      logic [OFS_W-1:0] full_hi;
      logic [OFS_W-1:0] full_lo;
      logic [OFS_W-1:0] empty_hi;
      logic [OFS_W-1:0] empty_lo;
   } dcf_ofs_t;

   localparam dcf_ofs_t OFS_RST =
      {FULL_HI_RST, FULL_LO_RST, EMPTY_HI_RST, EMPTY_LO_RST};

   // ==========================================================
   // helpers
   // ==========================================================
   // gray pointer back to binary
   function automatic logic [PTR_W-1:0] dcf_gray2bin
      (input logic [PTR_W-1:0] g);
      logic [PTR_W-1:0] b;
      b = '0;
      b[PTR_W-1] = g[PTR_W-1];
      for (int i = PTR_W - 2; i >= 0; i--)
      begin
         b[i] = b[i+1] ^ g[i];
      end
      return b;
   endfunction

endpackage

// ==== testbench/dcf_reader.sv ====
// reading host model: drives the read enables and resolves the output bus
`timescale 1ns/1ps
module dcf_reader
(
   input wire logic rd_clk_i,
   input wire logic go_i,
   input wire logic ld_i,
   input wire logic empty_flag_n_i,
   input wire logic oe_i,
   input wire logic [dcf_pkg::DATA_W-1:0] data_i,
   output logic ren_n_o,
   output logic got_o,
   output logic [dcf_pkg::DATA_W-1:0] word_o
);
   logic pend;
   logic g;
   logic [dcf_pkg::DATA_W-1:0] last;
   logic [dcf_pkg::DATA_W-1:0] bus;

   // ==========================================================
   // bus and read handshake
   // ==========================================================
   // a released bus shows the inverse of the last driven word
   assign bus = oe_i ? data_i : ~last;

   initial
   begin
      ren_n_o = 1'b1;
      got_o = 1'b0;
      pend = 1'b0;
      last = 9'h000;
      word_o = 9'h000;
   end

   // enables change just after the edge, from the value seen at the edge
   always @(posedge rd_clk_i)
   begin
      g = go_i;
      #1;
      ren_n_o = !g;
   end

   // a taken read is picked up at the following edge
   always @(posedge rd_clk_i)
   begin
      got_o <= pend;
      word_o <= bus;
      pend <= !ren_n_o && (empty_flag_n_i || ld_i);
      if (oe_i)
      begin
         last <= data_i;
      end
   end
endmodule // dcf_reader

// ==== testbench/tb_top.sv ====
// self-checking bench for the dual clock fifo
`timescale 1ns/1ps
module tb_top;
   logic ref_clk, rd_clk, reset, wen_n, pin, oe_n, go, ld;
   logic [dcf_pkg::DATA_W-1:0] wdata, rdata, word, last_w;
   logic rd_oe, ef_n, ff_n, ae_n, af_n, ren_n, got;
   logic [dcf_pkg::DATA_W-1:0] q[$];
   logic [7:0] rb [5] = '{8'h05, 8'h00, 8'h0A, 8'h00, 8'h05};
   int num_errors = 0;
   int n_checks = 0;
   int seed = 32'h360EFD88;

   // ==========================================================
   // design, host model and clocks
   // ==========================================================
   dcf_fifo dcf_fifo_inst (.ref_clk_i(ref_clk), .rd_clk_i(rd_clk),
      .reset_i(reset), .primary_write_enable_n_i(wen_n),
      .second_enable_or_load_n_i(pin), .write_data_i(wdata),
      .read_enable_a_n_i(ren_n), .read_enable_b_n_i(ren_n),
      .output_enable_n_i(oe_n), .read_data_o(rdata),
      .read_data_oe_o(rd_oe), .empty_flag_n_o(ef_n),
      .full_flag_n_o(ff_n), .almost_empty_flag_n_o(ae_n),
      .almost_full_flag_n_o(af_n));

   dcf_reader dcf_reader_inst (.rd_clk_i(rd_clk), .go_i(go), .ld_i(ld),
      .empty_flag_n_i(ef_n), .oe_i(rd_oe), .data_i(rdata),
      .ren_n_o(ren_n), .got_o(got), .word_o(word));

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   initial
   begin
      rd_clk = 1'b0;
      #1.3;
      forever #6 rd_clk = ~rd_clk;
   end

   // ==========================================================
   // checking and bus tasks
   // ==========================================================
   task automatic check(input string nm, input logic [8:0] seen,
      input logic [8:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic flag(input string nm, input logic seen, input logic exp);
      check(nm, {8'h00, seen}, {8'h00, exp});
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // one write cycle; the expected word is noted when it is stored
   task automatic wr(input logic [8:0] d, input logic p, input bit push);
      @(posedge ref_clk);
      #1;
      wen_n = 1'b0;
      pin = p;
      wdata = d;
      @(posedge ref_clk);
      #1;
      wen_n = 1'b1;
      if (push)
      begin
         q.push_back(d);
         last_w = d;
      end
   endtask

   // no reads or writes while reset is held
   task automatic rst(input logic strap);
      pin = strap;
      go = 1'b0;
      ld = 1'b0;
      wen_n = 1'b1;
      @(posedge ref_clk);
      #1;
      reset = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      flag("empty in reset", ef_n, 1'b0);
      flag("full in reset", ff_n, 1'b1);
      flag("almost empty in reset", ae_n, 1'b0);
      flag("almost full in reset", af_n, 1'b1);
      reset = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      check("data after reset", rdata, 9'h000);
      pin = 1'b1;
   endtask

   // reader stalls at random until every noted word came out
   task automatic drain();
      for (int i = 0; i < 3000 && q.size() > 0; i++)
      begin
         @(posedge rd_clk);
         #1;
         go = 1'($random(seed));
      end
      go = 1'b1;
      repeat (10) @(posedge rd_clk);
      #1;
      flag("drained", q.size() == 0, 1'b1);
      flag("empty after drain", ef_n, 1'b0);
      check("data held when empty", rdata, last_w);
      go = 1'b0;
   endtask

   // fill to full with the reader stalled, flags checked at every count
   task automatic fill(input int n, input int m);
      logic [8:0] d;
      for (int k = 1; k <= 64; k++)
      begin
         d = 9'($random(seed));
         wr(d, 1'b1, 1'b1);
         repeat (8) @(posedge ref_clk);
         #1;
         flag("almost full", af_n, k < 64 - m);
         flag("almost empty", ae_n, k > n);
         flag("full", ff_n, k < 64);
         flag("empty", ef_n, 1'b1);
      end
      wr(9'($random(seed)), 1'b1, 1'b0);
      flag("full held", ff_n, 1'b0);
      drain();
   endtask

   // ==========================================================
   // output monitor
   // ==========================================================
   always @(posedge rd_clk)
   begin
      if (got === 1'b1)
      begin
         if (q.size() == 0)
         begin
            n_checks++;
            num_errors++;
            $display("CHECK FAILED word expected none seen %h", word);
         end
         else
            check("read word", word, q.pop_front());
      end
   end

   initial
   begin
      #100000;
      num_errors++;
      $display("watchdog expired");
      summarize();
   end

   // ==========================================================
   // main sequence
   // ==========================================================
   initial
   begin
      reset = 1'b1;
      wen_n = 1'b1;
      pin = 1'b1;
      wdata = 9'h000;
      oe_n = 1'b0;
      go = 1'b0;
      ld = 1'b0;
      last_w = 9'h000;
      rst(1'b1);
      wr(9'($random(seed)), 1'b0, 1'b0);
      fill(7, 7);
      $display("test dual enable mode done");
      oe_n = 1'b1;
      repeat (4) @(posedge rd_clk);
      #1;
      flag("output released", rd_oe, 1'b0);
      oe_n = 1'b0;
      repeat (4) @(posedge rd_clk);
      #1;
      flag("output driven", rd_oe, 1'b1);
      $display("test output enable done");
      rst(1'b0);
      wr(9'h033, 1'b0, 1'b0);
      pin = 1'b1;
      repeat (4) @(posedge ref_clk);
      wr(9'h000, 1'b0, 1'b0);
      wr(9'h00A, 1'b0, 1'b0);
      wr(9'h000, 1'b0, 1'b0);
      wr(9'h005, 1'b0, 1'b0);
      ld = 1'b1;
      repeat (4) @(posedge rd_clk);
      #1;
      foreach (rb[i])
         q.push_back({1'b0, rb[i]});
      go = 1'b1; // loads finished before reads start
      repeat (5) @(posedge rd_clk);
      #1;
      go = 1'b0;
      repeat (6) @(posedge rd_clk);
      #1;
      flag("threshold reads", q.size() == 0, 1'b1);
      $display("test threshold access done");
      ld = 1'b0;
      pin = 1'b1;
      repeat (6) @(posedge rd_clk);
      fill(5, 10);
      $display("test programmed flags done");
      summarize();
   end
endmodule // tb_top
